// File: design/ptr_pkg.sv
// Purpose: Shared constants for the channel telemetry readback block.
// Assumes: Four channels, 14-bit results, 10 MHz system clock.
// Notes: Command codes double as register offsets on the serial bus.
package ptr_pkg;
   // Channel count and result width.
   localparam int CHANNELS = 4;
   localparam int CODE_W = 14;
   localparam int BYTE_W = 8;

   // Field positions inside a 16-bit result word.
   localparam int LOW_BYTE_LSB = 0;
   localparam int HIGH_BYTE_LSB = 8;

   // Reset value of every result register.
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Command codes of the voltage results, one per channel.
   localparam logic [7:0] CHANNEL1_PORT_VOLTAGE = 8'h32;
   localparam logic [7:0] CHANNEL2_PORT_VOLTAGE = 8'h36;
   localparam logic [7:0] CHANNEL3_PORT_VOLTAGE = 8'h3A;
   localparam logic [7:0] CHANNEL4_PORT_VOLTAGE = 8'h3E;
   localparam logic [3:0][7:0] VOLT_CMD = {CHANNEL4_PORT_VOLTAGE, CHANNEL3_PORT_VOLTAGE,
                                           CHANNEL2_PORT_VOLTAGE, CHANNEL1_PORT_VOLTAGE};
   // Command codes of the current results, channel one at index zero.
   localparam logic [3:0][7:0] CHANNEL_PORT_CURRENT = {8'h3C, 8'h38, 8'h34, 8'h30};

   // Channel operating modes as driven by the port controller.
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_DIAG = 2'h1;
   localparam logic [1:0] MODE_SEMIAUTO = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;

   // Refresh interval of the powered current result.
   localparam longint CLOCK_HZ = 10000000;
   localparam longint REFRESH_MS = 100;
   localparam int REFRESH_CYCLES = int'((CLOCK_HZ * REFRESH_MS) / 1000);
   localparam int REFRESH_W = 20;

   // Weights of one code, for software scaling only.
   localparam int CUR_STEP_NA = 89500;
   localparam int CUR_FULL_SCALE_MA = 1460;
   localparam int CLASS_SCALE_DIV = 10;
   localparam int CLASS_STEP_NA = CUR_STEP_NA / CLASS_SCALE_DIV;
   localparam int VOLTAGE_LSB_WEIGHT_UV = 3662;
   localparam int VOLT_FULL_SCALE_V = 60;

   // Seven-bit bus address; the value is arbitrary.
   localparam logic [6:0] DEV_ADDR = 7'h20;
endpackage : ptr_pkg

// File: design/ptr_link_if.sv
// Purpose: Carries commands and read bytes between the serial engine and the register logic.
// Assumes: Both ends run on the same clock.
// Notes: Strobes are one-cycle pulses.
`timescale 1ns/1ps
interface ptr_link_if;
   logic cmdStrobe; // Command byte received.
   logic [7:0] cmdByte; // Command byte value.
   logic rdLoad; // Next read byte wanted.
   logic rdFirst; // Request is first after a read address.
   logic [7:0] txByte; // Byte to shift out.

   modport engine (output cmdStrobe, output cmdByte, output rdLoad, output rdFirst, input txByte);
   modport regs (input cmdStrobe, input cmdByte, input rdLoad, input rdFirst, output txByte);
endinterface : ptr_link_if

// File: design/ptr_serial_engine.sv
// Purpose: Two-wire serial slave: address, one command byte, then read bytes.
// Assumes: Bus far slower than the clock; pins sampled directly.
// Notes: Data bytes after a command are not acknowledged, the results are read only.
`timescale 1ns/1ps
module ptr_serial_engine #(
   parameter logic [6:0] ADDR = ptr_pkg::DEV_ADDR
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Serial pins.
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOe,
   // Register side.
   ptr_link_if.engine link
);
   typedef enum logic [2:0] {IDLE, ADDR_RX, ADDR_ACK, CMD_RX, CMD_ACK, TX, TX_ACK, IGNORE} ptr_link_state_t;
   typedef struct packed {
      ptr_link_state_t st; // Protocol phase.
      logic sclPrev; // Clock line one cycle ago.
      logic sdaPrev; // Data line one cycle ago.
      logic [3:0] cnt; // Bits moved in this byte.
      logic [7:0] sh; // Shift register.
      logic rw; // Read requested.
      logic oe; // Pulling data low.
      logic cmdStrobe; // Command pulse.
      logic rdLoad; // Byte request pulse.
      logic rdFirst; // First request of a read.
   } ptr_engine_t;
   ptr_engine_t s;
   ptr_engine_t next_s;

   assign sdaOe = s.oe;
   assign link.cmdStrobe = s.cmdStrobe;
   assign link.cmdByte = s.sh;
   assign link.rdLoad = s.rdLoad;
   assign link.rdFirst = s.rdFirst;

   // Bit engine: sample on clock rise, change data on clock fall.
   always_comb begin
      logic rise;
      logic fall;
      rise = scl && !s.sclPrev;
      fall = !scl && s.sclPrev;
      next_s = s;
      next_s.sclPrev = scl;
      next_s.sdaPrev = sdaIn;
      next_s.cmdStrobe = 1'b0;
      next_s.rdLoad = 1'b0;
      next_s.rdFirst = 1'b0;
      if (scl && s.sclPrev && s.sdaPrev && !sdaIn) begin
         // Start or repeated start restarts address reception.
         next_s.st = ADDR_RX;
         next_s.cnt = 4'h0;
         next_s.oe = 1'b0;
      end else if (scl && s.sclPrev && !s.sdaPrev && sdaIn) begin
         // Stop releases the bus.
         next_s.st = IDLE;
         next_s.oe = 1'b0;
      end else begin
         unique case (s.st)
            IDLE, IGNORE: next_s.oe = 1'b0;
            ADDR_RX, CMD_RX: begin
               if (rise) begin
                  next_s.sh = {s.sh[6:0], sdaIn};
                  next_s.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == 4'h8) begin
                  next_s.cnt = 4'h0;
                  if (s.st == CMD_RX) begin
                     next_s.cmdStrobe = 1'b1;
                     next_s.st = CMD_ACK;
                     next_s.oe = 1'b1;
                  end else if (s.sh[7:1] == ADDR) begin
                     next_s.st = ADDR_ACK;
                     next_s.oe = 1'b1;
                     next_s.rw = s.sh[0];
                     next_s.rdLoad = s.sh[0];
                     next_s.rdFirst = s.sh[0];
                  end else begin
                     next_s.st = IGNORE;
                  end
               end
            end
            ADDR_ACK: begin
               if (fall && s.rw) begin
                  next_s.st = TX;
                  next_s.oe = !link.txByte[7];
                  next_s.sh = {link.txByte[6:0], 1'b0};
                  next_s.cnt = 4'h1;
               end else if (fall) begin
                  next_s.st = CMD_RX;
                  next_s.oe = 1'b0;
               end
            end
            CMD_ACK: begin
               if (fall) begin
                  next_s.st = IGNORE;
                  next_s.oe = 1'b0;
               end
            end
            TX: begin
               if (fall && s.cnt == 4'h8) begin
                  next_s.st = TX_ACK;
                  next_s.oe = 1'b0;
               end else if (fall) begin
                  next_s.oe = !s.sh[7];
                  next_s.sh = {s.sh[6:0], 1'b0};
                  next_s.cnt = s.cnt + 4'h1;
               end
            end
            TX_ACK: begin
               // Master acknowledge asks for one more byte.
               if (rise && sdaIn) begin
                  next_s.st = IGNORE;
               end else if (rise) begin
                  next_s.rdLoad = 1'b1;
               end else if (fall) begin
                  next_s.st = TX;
                  next_s.oe = !link.txByte[7];
                  next_s.sh = {link.txByte[6:0], 1'b0};
                  next_s.cnt = 4'h1;
               end
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '{st: IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, cnt: 4'h0, sh: 8'h00, rw: 1'b0,
                oe: 1'b0, cmdStrobe: 1'b0, rdLoad: 1'b0, rdFirst: 1'b0};
      end else begin
         s <= next_s;
      end
   end
endmodule : ptr_serial_engine

// File: design/ptr_telemetry_readback.sv
// Purpose: Per-channel current and voltage telemetry read over a two-wire serial bus.
// Assumes: Converter results, modes and class events arrive synchronous to clock.
// Notes: Result scaling is applied by software; classScale says which current step holds.
// Behaviour
// (RULE_01) Read-only 14-bit current result, reset zero.
// (RULE_02) Powered current refreshed about every 100 ms.
// (RULE_03) Current step 89.5 uA, full scale 1.46 A.
// (RULE_04) Off or idle semiauto channels read zero.
// (RULE_05) Diagnostic mode keeps last value once enabled.
// (RULE_06) Class current shown until powered reading or disable.
// (RULE_07) Class current uses ten times finer step.
// (RULE_08) Two bytes, low first, top bits zero.
// (RULE_09) Codes 32h, 36h, 3Ah read channel voltages.
// (RULE_10) Code 3Eh reads channel four voltage.
// (RULE_11) Codes 30h to 3Ch read channel currents.
// (RULE_12) Voltage step 3.662 mV, full scale 60 V.
// (RULE_13) Low byte read latches both bytes.
`timescale 1ns/1ps
module ptr_telemetry_readback #(
   parameter int REFRESH_CYCLES = ptr_pkg::REFRESH_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Serial bus pins, data is open drain.
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Channel status from the port controller.
   input wire logic [3:0] portEnable,
   input wire logic [3:0] powered,
   input wire logic [3:0][1:0] chMode,
   input wire logic [3:0] detClassEn,
   input wire logic [3:0] detectBad,
   // Classification results.
   input wire logic [3:0] classDone,
   input wire logic [3:0][13:0] classCurrent,
   // Converter results.
   input wire logic [3:0][13:0] adcCurrent,
   input wire logic [3:0][13:0] adcVoltage,
   // Scale of each current result: high means class step.
   output logic [3:0] classScale
);
   typedef struct packed {
      logic [3:0][13:0] curCode; // Stored current results.
      logic [3:0][13:0] voltCode; // Stored voltage codes.
      logic [3:0] classHeld; // Current result holds class current.
      logic [3:0] everEnabled; // Diagnostic detect or class seen.
      logic [ptr_pkg::REFRESH_W-1:0] tickCnt; // Refresh divider.
      logic [7:0] cmd; // Last command code.
      logic [15:0] shadow; // Word frozen at low byte read.
      logic [7:0] txByte; // Byte offered to the engine.
      logic highNext; // Next read byte is the high byte.
      logic sdaOut; // Open-drain data level, always low.
   } ptr_regs_t;
   ptr_regs_t r;
   ptr_regs_t next_r;

   // Link between the register logic and the serial engine.
   ptr_link_if link ();

   localparam logic [ptr_pkg::REFRESH_W-1:0] TICK_LAST = ptr_pkg::REFRESH_W'(REFRESH_CYCLES - 1);

   // Decides if a channel's current must read as zero.
   function automatic logic forceZero(input logic [1:0] mode, input logic pw, input logic dce,
                                      input logic bad, input logic ever);
      logic z;
      z = 1'b0;
      if (mode == ptr_pkg::MODE_OFF) begin
         z = 1'b1; // [RULE_04]
      end else if (mode == ptr_pkg::MODE_SEMIAUTO && !pw && (!dce || bad)) begin
         z = 1'b1; // [RULE_04]
      end else if (mode == ptr_pkg::MODE_DIAG && !ever) begin
         z = 1'b1; // Nothing measured yet, so nothing to keep.
      end
      return z;
   endfunction : forceZero

   // Maps a command code to the 16-bit word it reads.
   function automatic logic [15:0] readWord(input ptr_regs_t q, input logic [3:0][1:0] mode,
                                            input logic [3:0] pw, input logic [3:0] dce,
                                            input logic [3:0] bad);
      logic [15:0] w;
      w = ptr_pkg::RESULT_RESET;
      for (int ch = 0; ch < ptr_pkg::CHANNELS; ch++) begin
         if (q.cmd == ptr_pkg::CHANNEL_PORT_CURRENT[ch]) begin
            // Diagnostic mode keeps its last value once enabled.
            if (!forceZero(mode[ch], pw[ch], dce[ch], bad[ch], q.everEnabled[ch])) begin
               w = {2'b00, q.curCode[ch]}; // [RULE_11] [RULE_05] [RULE_01]
            end
         end
         if (q.cmd == ptr_pkg::VOLT_CMD[ch]) begin
            w = {2'b00, q.voltCode[ch]}; // [RULE_09] [RULE_10] [RULE_12]
         end
      end
      return w;
   endfunction : readWord

   ptr_serial_engine u_engine (
      .clock(clock),
      .rst(rst),
      .scl(scl),
      .sdaIn(sdaIn),
      .sdaOe(sdaOe),
      .link(link.engine)
   );

   assign link.txByte = r.txByte;
   assign sdaOut = r.sdaOut;
   assign classScale = r.classHeld;

   // Result update, command capture and byte sequencing.
   always_comb begin
      logic tick;
      logic [15:0] word;
      next_r = r;
      tick = (r.tickCnt == TICK_LAST);
      word = readWord(r, chMode, powered, detClassEn, detectBad);
      // Free-running divider gives the refresh enable pulse.
      next_r.tickCnt = tick ? '0 : r.tickCnt + 1'b1; // [RULE_02]
      for (int ch = 0; ch < ptr_pkg::CHANNELS; ch++) begin
         if (chMode[ch] == ptr_pkg::MODE_DIAG && detClassEn[ch]) begin
            next_r.everEnabled[ch] = 1'b1; // [RULE_05]
         end else if (chMode[ch] != ptr_pkg::MODE_DIAG) begin
            next_r.everEnabled[ch] = 1'b0;
         end
         if (tick) begin
            next_r.voltCode[ch] = adcVoltage[ch]; // [RULE_12]
         end
         if (!portEnable[ch]) begin
            // Disabling the port drops any class reading.
            next_r.curCode[ch] = '0; // [RULE_06]
            next_r.classHeld[ch] = 1'b0; // [RULE_06]
         end else if (tick && powered[ch]) begin
            // A powered reading ends the class display and its fine step.
            next_r.curCode[ch] = adcCurrent[ch]; // [RULE_02] [RULE_03]
            next_r.classHeld[ch] = 1'b0; // [RULE_07]
         end else if (classDone[ch]) begin
            next_r.curCode[ch] = classCurrent[ch]; // [RULE_06]
            next_r.classHeld[ch] = 1'b1; // [RULE_07]
         end
      end
      if (link.cmdStrobe) begin
         next_r.cmd = link.cmdByte;
      end
      if (link.rdLoad && (link.rdFirst || !r.highNext)) begin
         // Freeze the whole word so the high byte matches the low byte.
         next_r.shadow = word; // [RULE_13]
         next_r.txByte = word[ptr_pkg::LOW_BYTE_LSB +: ptr_pkg::BYTE_W]; // [RULE_08]
         next_r.highNext = 1'b1;
      end else if (link.rdLoad) begin
         next_r.txByte = r.shadow[ptr_pkg::HIGH_BYTE_LSB +: ptr_pkg::BYTE_W]; // [RULE_08] [RULE_13]
         next_r.highNext = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule : ptr_telemetry_readback

// File: bench/ptr_readback_asserts.sv
// Purpose: Port-level checks of the telemetry readback block.
// Assumes: Single clock domain with an asynchronous active-high reset.
// Notes: Class flag checks run per channel; the hold counter watches channel one only.
`timescale 1ns/1ps
module ptr_readback_asserts #(
   parameter int REFRESH_CYCLES = 1000000
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Serial pins.
   input wire logic scl,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // Channel status and scale flags.
   input wire logic [3:0] portEnable,
   input wire logic [3:0] powered,
   input wire logic [3:0] classDone,
   input wire logic [3:0] classScale
);
   // Every check samples on the rising edge; all but chk_reset_quiet rest while reset is applied.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Cycles that channel one has shown a class reading while powered.
   logic [31:0] heldCount;
   // A stuck class flag would let this grow past one refresh period.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         heldCount <= 32'h00000000;
      end else begin
         heldCount <= (classScale[0] && powered[0] && portEnable[0]) ? heldCount + 32'h00000001 : 32'h00000000;
      end
   end
   // A classification result arrives on an enabled, unpowered channel.
   sequence s_loaded(logic done, logic en, logic pw);
      done && en && !pw;
   endsequence
   // A class reading is on show and nothing should replace it.
   sequence s_kept(logic sc, logic en, logic pw, logic done);
      sc && en && !pw && !done;
   endsequence
   chk_drive_low: assert property (sdaOut == 1'b0)
      else $error("data drive value not low");
   chk_reset_quiet: assert property (disable iff (1'b0) rst |-> !sdaOe && classScale == 4'h0)
      else $error("outputs active during reset");
   chk_sda_scl_low: assert property ($changed(sdaOe) |-> !scl)
      else $error("data line changed while serial clock high");
   chk_refresh_bound: assert property (heldCount <= REFRESH_CYCLES + 1)
      else $error("powered reading not refreshed in time");
   for (genvar i = 0; i < 4; i++) begin : g_ch
      chk_class_sets: assert property (s_loaded(classDone[i], portEnable[i], powered[i])
         |=> classScale[i])
         else $error("class flag not set after classification");
      chk_class_holds: assert property (s_kept(classScale[i], portEnable[i], powered[i], classDone[i])
         |=> classScale[i])
         else $error("class reading dropped early");
      chk_scale_cause: assert property ($rose(classScale[i]) |-> $past(classDone[i]))
         else $error("class flag rose without classification");
      chk_scale_release: assert property ($fell(classScale[i]) |-> $past(!portEnable[i] || powered[i]))
         else $error("class flag fell without cause");
      chk_disable_clears: assert property (!portEnable[i] && !classDone[i] |=> !classScale[i])
         else $error("class flag kept on disabled port");
   end
endmodule : ptr_readback_asserts

bind ptr_telemetry_readback ptr_readback_asserts #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_chk (.clock(clock), .rst(rst),
   .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .portEnable(portEnable), .powered(powered),
   .classDone(classDone), .classScale(classScale));

// File: bench/ptr_host_model.sv
// Purpose: Serial bus master model that reads two-byte result words.
// Assumes: Data line has a pull-up; timing counted in system clocks.
// Notes: Pins change only at falling clock edges, never together.
`timescale 1ns/1ps
module ptr_host_model #(
   parameter int HALF = 3
) (
   // Clock.
   input wire logic clock,
   // Bus lines.
   output logic scl,
   output logic sdaPull,
   input wire logic sda
);
   // Idle bus: both lines released high.
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   // Whole cycles between pin moves, so the sampler never sees a race.
   task automatic pause();
      repeat (HALF) @(negedge clock);
   endtask : pause
   // One bit slot; the line is released where b is one, sampled late in the high phase.
   task automatic bitIo(input logic b, output logic r);
      sdaPull = !b;
      pause();
      scl = 1'b1;
      pause();
      r = sda;
      scl = 1'b0;
      pause();
   endtask : bitIo
   // Start or repeated start: data falls while the serial clock is high.
   task automatic startCond();
      sdaPull = 1'b0;
      pause();
      scl = 1'b1;
      pause();
      sdaPull = 1'b1;
      pause();
      scl = 1'b0;
      pause();
   endtask : startCond
   // Eight bits, most significant first, then the acknowledge slot.
   task automatic byteIo(input logic [7:0] d, input logic ackIn, output logic [7:0] q, output logic ackOut);
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], q[i]);
      end
      bitIo(ackIn, ackOut);
   endtask : byteIo
   // Command write, repeated start, then low byte acked and high byte refused.
   task automatic readWord(input logic [6:0] addr, input logic [7:0] cmd, output logic [15:0] w, output logic ok);
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] junk;
      logic a0;
      logic a1;
      logic a2;
      logic an;
      startCond();
      byteIo({addr, 1'b0}, 1'b1, junk, a0);
      byteIo(cmd, 1'b1, junk, a1);
      startCond();
      byteIo({addr, 1'b1}, 1'b1, junk, a2);
      byteIo(8'hFF, 1'b0, lo, an);
      byteIo(8'hFF, 1'b1, hi, an);
      sdaPull = 1'b1;
      pause();
      scl = 1'b1;
      pause();
      sdaPull = 1'b0;
      pause();
      w = {hi, lo};
      ok = !a0 && !a1 && !a2;
   endtask : readWord
endmodule : ptr_host_model

// File: bench/testbench.sv
// Purpose: Self-checking bench for the telemetry readback block.
// Assumes: Short refresh period; host model drives the serial pins.
// Notes: Channel inputs change at falling clock edges only.
`timescale 1ns/1ps
module testbench;
   // Short refresh keeps the run brief; waits derive from it.
   localparam int REFRESH = 6000;
   logic clock, rst, scl, hostPull, sdaOut, sdaOe, sda;
   logic [3:0] portEnable, powered, detClassEn, detectBad, classDone, classScale;
   logic [3:0][1:0] chMode;
   logic [3:0][13:0] classCurrent, adcCurrent, adcVoltage;
   int fails, num_checks;
   // Open-drain line with pull-up.
   assign sda = !(sdaOe || hostPull);
   ptr_telemetry_readback #(.REFRESH_CYCLES(REFRESH)) i_dut (.clock(clock), .rst(rst), .scl(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .portEnable(portEnable), .powered(powered), .chMode(chMode),
      .detClassEn(detClassEn), .detectBad(detectBad), .classDone(classDone), .classCurrent(classCurrent),
      .adcCurrent(adcCurrent), .adcVoltage(adcVoltage), .classScale(classScale));
   ptr_host_model i_host (.clock(clock), .scl(scl), .sdaPull(hostPull), .sda(sda));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic waitCycles(input int n);
      repeat (n) @(negedge clock);
   endtask : waitCycles
   // One full read, address acks included.
   task automatic readCheck(input string name, input logic [7:0] cmd, input logic [15:0] exp);
      logic [15:0] w;
      logic ok;
      i_host.readWord(ptr_pkg::DEV_ADDR, cmd, w, ok);
      check({name, " ack"}, {15'h0000, ok}, 16'h0001);
      check(name, w, exp);
   endtask : readCheck
   // One-cycle classification pulse on channel one.
   task automatic pulseClass();
      classDone[0] = 1'b1;
      waitCycles(1);
      classDone[0] = 1'b0;
      waitCycles(1);
   endtask : pulseClass
   // Before the first refresh every result still reads zero.
   task automatic resetValues();
      check("scale", {12'h000, classScale}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         readCheck("voltage", ptr_pkg::VOLT_CMD[i], 16'h0000);
         readCheck("current", ptr_pkg::CHANNEL_PORT_CURRENT[i], 16'h0000);
      end
   endtask : resetValues
   // Live codes, plus each off or idle semiauto case that forces a current reading to zero.
   task automatic liveReadings();
      logic [15:0] expCur;
      waitCycles(REFRESH);
      chMode[1] = ptr_pkg::MODE_OFF;
      chMode[3:2] = {2{ptr_pkg::MODE_SEMIAUTO}};
      powered[3:2] = 2'h0;
      detClassEn[2] = 1'b0;
      detectBad[3] = 1'b1;
      for (int i = 0; i < 4; i++) begin
         expCur = (i == 0) ? {2'h0, adcCurrent[0]} : 16'h0000;
         readCheck("voltage", ptr_pkg::VOLT_CMD[i], {2'h0, adcVoltage[i]});
         readCheck("current", ptr_pkg::CHANNEL_PORT_CURRENT[i], expCur);
      end
      detectBad[3] = 1'b0;
      readCheck("current", ptr_pkg::CHANNEL_PORT_CURRENT[3], {2'h0, adcCurrent[3]});
   endtask : liveReadings
   // Class reading shown, replaced by a powered reading, then cleared by disable.
   task automatic classReading();
      powered[0] = 1'b0;
      classCurrent[0] = 14'h0ABC;
      pulseClass();
      check("scale", {15'h0000, classScale[0]}, 16'h0001);
      readCheck("class", ptr_pkg::CHANNEL_PORT_CURRENT[0], 16'h0ABC);
      powered[0] = 1'b1;
      waitCycles(REFRESH + 2);
      check("scale", {15'h0000, classScale[0]}, 16'h0000);
      readCheck("current", ptr_pkg::CHANNEL_PORT_CURRENT[0], {2'h0, adcCurrent[0]});
      powered[0] = 1'b0;
      pulseClass();
      portEnable[0] = 1'b0;
      waitCycles(2);
      check("scale", {15'h0000, classScale[0]}, 16'h0000);
      readCheck("current", ptr_pkg::CHANNEL_PORT_CURRENT[0], 16'h0000);
      portEnable[0] = 1'b1;
   endtask : classReading
   // Diagnostic mode reads zero until enabled once, then keeps its value.
   task automatic diagHold();
      chMode[1] = ptr_pkg::MODE_DIAG;
      detClassEn[1] = 1'b0;
      readCheck("diag", ptr_pkg::CHANNEL_PORT_CURRENT[1], 16'h0000);
      detClassEn[1] = 1'b1;
      waitCycles(REFRESH + 2);
      detClassEn[1] = 1'b0;
      powered[1] = 1'b0;
      readCheck("diag", ptr_pkg::CHANNEL_PORT_CURRENT[1], {2'h0, adcCurrent[1]});
   endtask : diagHold
   // A conversion that lands between the two bytes must not split the word.
   task automatic latchedRead();
      pulseClass();
      powered[0] = 1'b1;
      // The class flag falls on a refresh tick, which fixes the phase of the next one.
      for (int n = 0; n <= REFRESH && classScale[0]; n++) begin
         waitCycles(1);
      end
      check("tick", {15'h0000, classScale[0]}, 16'h0000);
      // The next tick then falls after the low byte is latched and before the high byte goes out.
      waitCycles(REFRESH - 300);
      adcCurrent[0] = 14'h12FE;
      readCheck("latched", ptr_pkg::CHANNEL_PORT_CURRENT[0], 16'h2001);
      readCheck("current", ptr_pkg::CHANNEL_PORT_CURRENT[0], 16'h12FE);
   endtask : latchedRead
   // Unknown command reads zero; a foreign address is ignored.
   task automatic refusedAccess();
      logic [15:0] w;
      logic ok;
      readCheck("unknown", 8'h40, 16'h0000);
      i_host.readWord(ptr_pkg::DEV_ADDR ^ 7'h01, ptr_pkg::CHANNEL_PORT_CURRENT[0], w, ok);
      check("foreign ack", {15'h0000, ok}, 16'h0000);
      check("foreign data", w, 16'hFFFF);
   endtask : refusedAccess
   // A hang is cut short and counted as a mismatch.
   initial begin
      repeat (100000) @(posedge clock);
      fails++;
      results();
   end
   initial begin
      fails = 0;
      num_checks = 0;
      rst = 1'b1;
      portEnable = 4'hF;
      powered = 4'hF;
      chMode = {4{ptr_pkg::MODE_AUTO}};
      detClassEn = 4'hF;
      detectBad = 4'h0;
      classDone = 4'h0;
      classCurrent = {4{14'h0000}};
      adcCurrent = {14'h3FFF, 14'h2A5C, 14'h0155, 14'h2001};
      adcVoltage = {14'h3ABC, 14'h1F0F, 14'h2468, 14'h0001};
      waitCycles(2);
      rst = 1'b0;
      waitCycles(2);
      resetValues();
      liveReadings();
      classReading();
      diagHold();
      latchedRead();
      refusedAccess();
      results();
   end
endmodule : testbench
